// file: dbam_pkg.sv
// package: address map constants for the direct bank address mapper
package dbam_pkg;
  localparam logic [15:0] IO_LO = 16'h0000;
  localparam logic [15:0] IO_HI = 16'h007f;
  localparam logic [15:0] PROHIB_LO = 16'h0080;
  localparam logic [15:0] PROHIB_HI = 16'h008f;
  localparam logic [15:0] DIRRAM_LO = 16'h0090;
  localparam logic [15:0] GPR_LO = 16'h0100;
  localparam logic [15:0] GPR_HI = 16'h01ff;
  localparam logic [15:0] XIO_LO = 16'h0f80;
  localparam logic [15:0] XIO_HI = 16'h0fff;
  localparam logic [15:0] NVR_LO = 16'hffbb;
  localparam logic [15:0] NVR_HI = 16'hffbf;
  localparam logic [15:0] VEC_LO = 16'hffc0;
  localparam logic [15:0] VEC_HI = 16'hffff;
  localparam logic [15:0] RAM_END_DEF = 16'h047f;
  localparam logic [7:0] MIRROR_ADDR = 8'h78;
  localparam logic [2:0] DBS_RESET = 3'h0;
  localparam logic [4:0] RBS_RESET = 5'h00;
  localparam logic [15:0] FLASH_LO_DEF = 16'h2000;
  typedef enum logic [2:0] {
    DBAM_R_NONE, DBAM_R_IO, DBAM_R_RAM, DBAM_R_XIO, DBAM_R_FLASH, DBAM_R_NVR, DBAM_R_VEC
  } dbam_region_t;
endpackage

// file: dbam_xlat_if.sv
// interface: operand-to-address translation request and result
`timescale 1ns/1ps
interface dbam_xlat_if;
  logic [15:0] addr_in;
  logic direct;
  logic [2:0] bank;
  logic [15:0] addr_out;
  logic prohibited;
  modport req (output addr_in, output direct, output bank, input addr_out, input prohibited);
  modport rsp (input addr_in, input direct, input bank, output addr_out, output prohibited);
endinterface

// file: dbam_xlat.sv
// direct-operand bank translation, combinational
`timescale 1ns/1ps
module dbam_xlat #(
  parameter logic [15:0] RAM_END = dbam_pkg::RAM_END_DEF
) (
  dbam_xlat_if.rsp x
);
  logic [15:0] banked;
  always_comb begin
    // window base is 0x80*(n+1): bank plus one forms bits 10..7
    banked = {5'h00, {1'b0, x.bank} + 4'h1, x.addr_in[6:0]};
    if (x.bank == 3'h7) begin
      banked = {5'h00, 4'h8, x.addr_in[6:0]};
    end
    x.addr_out = x.addr_in;
    x.prohibited = 1'b0;
    if (x.direct) begin
      if (x.addr_in[15:7] == 9'h000) begin
        x.addr_out = x.addr_in;
      end else if (x.addr_in[15:8] != 8'h00) begin
        x.prohibited = 1'b1;
      end else if (x.bank == 3'h0) begin
        x.addr_out = x.addr_in;
        x.prohibited = (x.addr_in <= dbam_pkg::PROHIB_HI);
      end else begin
        x.addr_out = banked;
        x.prohibited = (banked > RAM_END);
      end
    end
  end
endmodule

// file: dbam_top.sv
// top: address decode, direct bank translation and bank pointer mirror
// What this block does
// - 0x0100-0x01FF holds auxiliary byte registers for arithmetic and transfers.
// - register area is plain RAM for ordinary reads and writes.
// - a register addressing form reaches the register area with short operands.
// - flash 0xFFBB-0xFFBF is reserved for non-volatile register contents.
// - 0xFFC0-0xFFFF is the vector table for vector call, interrupt, reset.
// - vector entries hold handler start addresses, loaded as the new target.
// - direct operands 0x00-0x7F map unchanged whatever the bank pointer.
// - 3-bit bank pointer, reset 0; nonzero maps 0x80-0xFF to 0x80*(n+1).
// - banked window stops where physical RAM ends in smaller variants.
// - I/O 0x78 mirrors register bank and direct bank pointers.
// - 0x00-0x7F is I/O, reached by ordinary and direct accesses.
// - 0xF80-0xFFF is extended I/O, ordinary accesses only.
`timescale 1ns/1ps
module dbam_top #(
  parameter logic [15:0] RAM_END = dbam_pkg::RAM_END_DEF,
  parameter logic [15:0] FLASH_LO = dbam_pkg::FLASH_LO_DEF
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic acc_valid,
  input wire logic [1:0] acc_mode,
  input wire logic [15:0] acc_addr,
  input wire logic acc_write,
  input wire logic [7:0] acc_wdata,
  input wire logic [2:0] gpr_index,
  input wire logic vec_fetch,
  input wire logic [4:0] vec_index,
  input wire logic [15:0] mem_rdata,
  output logic out_valid,
  output logic [15:0] out_addr,
  output logic out_write,
  output logic [7:0] out_wdata,
  output logic [2:0] out_region,
  output logic out_prohibited,
  output logic mirror_hit,
  output logic [7:0] mirror_rdata,
  output logic [2:0] direct_bank_select,
  output logic [4:0] register_bank_select,
  output logic vec_fetch_pending,
  output logic [15:0] vec_target,
  output logic vec_target_valid
);
  // acc_mode: 0 ordinary, 1 direct operand, 2 register form (gpr_index)
  localparam logic [1:0] MODE_DIRECT = 2'h1;
  localparam logic [1:0] MODE_GPR = 2'h2;
  // ==========================================================
  // registers behind the output ports
  logic [2:0] dbs_r;
  logic [4:0] rbs_r;
  logic mirror_hit_r;
  logic [7:0] mirror_rdata_r;
  logic out_valid_r;
  logic [15:0] out_addr_r;
  logic out_write_r;
  logic [7:0] out_wdata_r;
  logic [2:0] out_region_r;
  logic out_prohibited_r;
  logic vec_pending_r;
  logic vec_phase_r;
  logic [7:0] vec_hi_r;
  logic [15:0] vec_target_r;
  logic vec_target_valid_r;
  // ==========================================================
  // translation
  dbam_xlat_if xi ();
  logic is_direct;
  logic is_gpr;
  logic req;
  logic [15:0] gpr_addr;
  logic [15:0] vec_addr;
  logic [15:0] phys;
  logic prohib;
  dbam_pkg::dbam_region_t region;
  assign is_direct = (acc_mode == MODE_DIRECT);
  assign is_gpr = (acc_mode == MODE_GPR);
  assign req = acc_valid || vec_fetch;
  // eight registers per bank, so 32 banks fill the whole register area
  assign gpr_addr = dbam_pkg::GPR_LO + {8'h00, rbs_r, gpr_index};
  // two bytes per vector entry, high byte at the even address
  assign vec_addr = dbam_pkg::VEC_LO + {10'h000, vec_index, 1'b0};
  assign xi.addr_in = acc_addr;
  assign xi.direct = acc_valid && is_direct;
  assign xi.bank = dbs_r;
  dbam_xlat #(.RAM_END(RAM_END)) u_xlat (.x(xi));
  // a vector fetch outranks any access offered in the same cycle, except that a refused direct operand refuses the fetch too
  always_comb begin
    phys = xi.addr_out;
    if (is_gpr) begin
      phys = gpr_addr;
    end
    if (vec_fetch) begin
      phys = vec_addr;
    end
  end
  // ==========================================================
  // region decode; a refused access carries no region
  always_comb begin
    prohib = xi.prohibited;
    if (phys <= dbam_pkg::IO_HI) begin
      region = dbam_pkg::DBAM_R_IO;
    end else if (phys >= dbam_pkg::DIRRAM_LO && phys <= RAM_END) begin
      region = dbam_pkg::DBAM_R_RAM;
    end else if (phys >= dbam_pkg::XIO_LO && phys <= dbam_pkg::XIO_HI) begin
      region = dbam_pkg::DBAM_R_XIO;
      if (is_direct) begin
        prohib = 1'b1;
      end
    end else if (phys >= dbam_pkg::VEC_LO) begin
      region = dbam_pkg::DBAM_R_VEC;
    end else if (phys >= dbam_pkg::NVR_LO && phys <= dbam_pkg::NVR_HI) begin
      region = dbam_pkg::DBAM_R_NVR;
    end else if (phys >= FLASH_LO) begin
      region = dbam_pkg::DBAM_R_FLASH;
    end else begin
      // the hole at 0x0080-0x008f and any space above the fitted ram
      region = dbam_pkg::DBAM_R_NONE;
      prohib = 1'b1;
    end
    if (prohib) begin
      region = dbam_pkg::DBAM_R_NONE;
    end
  end
  // ==========================================================
  // bank pointer mirror at i/o 0x78: bits 7:3 register bank, 2:0 direct bank
  logic is_mirror;
  logic bank_wr;
  assign is_mirror = acc_valid && !vec_fetch && !prohib
    && (phys == {8'h00, dbam_pkg::MIRROR_ADDR});
  // direct operand 0x78 lands here as well, since it maps unchanged
  assign bank_wr = is_mirror && acc_write;
  always_ff @(posedge clk) begin
    if (!resetn) begin
      dbs_r <= dbam_pkg::DBS_RESET;
      rbs_r <= dbam_pkg::RBS_RESET;
    end else if (bank_wr) begin
      dbs_r <= acc_wdata[2:0];
      rbs_r <= acc_wdata[7:3];
    end
  end
  always_ff @(posedge clk) begin
    if (!resetn) begin
      mirror_hit_r <= 1'b0;
      mirror_rdata_r <= 8'h00;
    end else begin
      mirror_hit_r <= is_mirror && !acc_write;
      mirror_rdata_r <= {rbs_r, dbs_r};
    end
  end
  // ==========================================================
  // access output stage; mirror accesses never reach the i/o bus
  logic fwd_ok;
  logic write_ok;
  assign fwd_ok = req && !prohib && !is_mirror;
  // the vector table and nvr bytes are never written as program space
  assign write_ok = acc_valid && acc_write && !vec_fetch && fwd_ok
    && region != dbam_pkg::DBAM_R_NVR && region != dbam_pkg::DBAM_R_VEC;
  always_ff @(posedge clk) begin
    if (!resetn) begin
      out_valid_r <= 1'b0;
      out_prohibited_r <= 1'b0;
      out_write_r <= 1'b0;
    end else begin
      out_valid_r <= fwd_ok;
      out_prohibited_r <= req && prohib;
      out_write_r <= write_ok;
    end
  end
  // address, data and region mean something only while out_valid is high
  always_ff @(posedge clk) begin
    if (!resetn) begin
      out_addr_r <= 16'h0000;
      out_wdata_r <= 8'h00;
      out_region_r <= 3'h0;
    end else begin
      out_addr_r <= phys;
      out_wdata_r <= acc_wdata;
      out_region_r <= region;
    end
  end
  // ==========================================================
  // vector fetch: two byte reads, high byte first, build handler address
  // a vector_call_instruction, an interrupt and a reset all enter here alike
  always_ff @(posedge clk) begin
    if (!resetn) begin
      vec_pending_r <= 1'b0;
      vec_phase_r <= 1'b0;
      vec_hi_r <= 8'h00;
    end else if (vec_fetch && !vec_pending_r) begin
      vec_pending_r <= 1'b1;
      vec_phase_r <= 1'b0;
    end else if (vec_pending_r) begin
      if (!vec_phase_r) begin
        vec_hi_r <= mem_rdata[7:0];
        vec_phase_r <= 1'b1;
      end else begin
        vec_pending_r <= 1'b0;
      end
    end
  end
  // a fetch offered while one is pending is dropped; the core must wait
  always_ff @(posedge clk) begin
    if (!resetn) begin
      vec_target_r <= 16'h0000;
      vec_target_valid_r <= 1'b0;
    end else begin
      vec_target_valid_r <= vec_pending_r && vec_phase_r;
      if (vec_pending_r && vec_phase_r) begin
        vec_target_r <= {vec_hi_r, mem_rdata[7:0]};
      end
    end
  end
  // ==========================================================
  // ports
  assign out_valid = out_valid_r;
  assign out_addr = out_addr_r;
  assign out_write = out_write_r;
  assign out_wdata = out_wdata_r;
  assign out_region = out_region_r;
  assign out_prohibited = out_prohibited_r;
  assign mirror_hit = mirror_hit_r;
  assign mirror_rdata = mirror_rdata_r;
  assign direct_bank_select = dbs_r;
  assign register_bank_select = rbs_r;
  assign vec_fetch_pending = vec_pending_r;
  assign vec_target = vec_target_r;
  assign vec_target_valid = vec_target_valid_r;
endmodule

// file: dbam_flash.sv
// partner: flash image answering vector entry reads
`timescale 1ns/1ps
module dbam_flash (
  input wire logic clk,
  input wire logic [15:0] out_addr,
  input wire logic vec_fetch_pending,
  output logic [15:0] mem_rdata
);
  logic ph_r = 1'b0;
  logic tg_r = 1'b0;
  logic [7:0] lo_r;
  // entry 0xffc0+2i holds 0x21c0+2i, high byte first
  always @(posedge clk) begin
    ph_r <= vec_fetch_pending && !ph_r;
    tg_r <= !tg_r;
    if (!ph_r) lo_r <= out_addr[7:0];
  end
  // idle bus toggles so a stale byte can never look right
  assign mem_rdata = !vec_fetch_pending ? {16{tg_r}} : {8'h00, ph_r ? lo_r : 8'h21};
endmodule

// file: dbam_chk.sv
// checker: direct bank translation and address map properties
`timescale 1ns/1ps
module dbam_chk #(parameter logic [15:0] RAM_END = dbam_pkg::RAM_END_DEF) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic acc_valid,
  input wire logic [1:0] acc_mode,
  input wire logic [15:0] acc_addr,
  input wire logic acc_write,
  input wire logic [7:0] acc_wdata,
  input wire logic [2:0] gpr_index,
  input wire logic out_valid,
  input wire logic [15:0] out_addr,
  input wire logic out_write,
  input wire logic [2:0] out_region,
  input wire logic out_prohibited,
  input wire logic [2:0] direct_bank_select,
  input wire logic [4:0] register_bank_select
);
  // =====================================================
  // properties
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  wire logic dir = acc_valid && acc_mode == 2'h1;
  wire logic ord = acc_valid && acc_mode == 2'h0;
  wire logic bnk = dir && acc_addr[15:7] == 9'h001 && direct_bank_select != 3'h0;
  wire logic [15:0] win = {5'h00, {1'b0, direct_bank_select} + 4'h1, acc_addr[6:0]};
  property p_io; dir && acc_addr <= 16'h007f && acc_addr != 16'h0078 |=>
    out_valid && out_region == 3'h1 && out_addr == $past(acc_addr); endproperty
  a_io: assert property (p_io) else $error("direct io moved");
  property p_win; bnk && win <= RAM_END |=> out_valid && out_addr == $past(win); endproperty
  a_win: assert property (p_win) else $error("bank window wrong");
  property p_end; bnk && win > RAM_END |=> !out_valid && out_prohibited; endproperty
  a_end: assert property (p_end) else $error("window past ram");
  property p_pro; dir && acc_addr[15:4] == 12'h008 && direct_bank_select == 3'h0
    |=> !out_valid && out_prohibited; endproperty
  a_pro: assert property (p_pro) else $error("hole mapped");
  property p_xio; dir && acc_addr[15:7] == 9'h01f |=> out_prohibited; endproperty
  a_xio: assert property (p_xio) else $error("ext io by direct");
  property p_ram; ord && acc_addr[15:8] == 8'h01 |=> out_valid && out_region == 3'h2; endproperty
  a_ram: assert property (p_ram) else $error("register area not ram");
  property p_gpr; acc_valid && acc_mode == 2'h2 |=> out_valid &&
    out_addr == 16'h0100 + {$past(register_bank_select), $past(gpr_index)}; endproperty
  a_gpr: assert property (p_gpr) else $error("register form address");
  property p_mir; ord && acc_write && acc_addr == 16'h0078 |=> !out_valid &&
    {register_bank_select, direct_bank_select} == $past(acc_wdata); endproperty
  a_mir: assert property (p_mir) else $error("mirror write lost");
  property p_nvw; ord && acc_write && acc_addr >= 16'hffbb |=> !out_write; endproperty
  a_nvw: assert property (p_nvw) else $error("nvr or vector written");
  c_b7: cover property (bnk && direct_bank_select == 3'h7);
  c_mir: cover property (ord && acc_write && acc_addr == 16'h0078);
  c_pro: cover property (out_prohibited);
  c_gpr: cover property (acc_valid && acc_mode == 2'h2);
endmodule
bind dbam_top dbam_chk #(.RAM_END(RAM_END)) u_chk (.clk, .resetn, .acc_valid, .acc_mode,
  .acc_addr, .acc_write, .acc_wdata, .gpr_index, .out_valid, .out_addr, .out_write, .out_region,
  .out_prohibited, .direct_bank_select, .register_bank_select);

// file: tb_top.sv
// testbench: address mapper against a flash image
`timescale 1ns/1ps
module tb_top;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic acc_valid = 1'b0;
  logic [1:0] acc_mode = 2'h0;
  logic [15:0] acc_addr = 16'h0000;
  logic acc_write = 1'b0;
  logic [7:0] acc_wdata = 8'h00;
  logic [2:0] gpr_index = 3'h0;
  logic vec_fetch = 1'b0;
  logic [4:0] vec_index = 5'h00;
  logic [15:0] mem_rdata, out_addr, vec_target;
  logic out_valid, out_write, out_prohibited, mirror_hit, vec_fetch_pending, vec_target_valid;
  logic [7:0] out_wdata, mirror_rdata;
  logic [2:0] out_region, direct_bank_select;
  logic [4:0] register_bank_select;
  int n_mismatch = 0;
  int compares = 0;
  always #50 clk = ~clk;
  // smaller variant, so the ram-end cut-off is reachable
  dbam_top #(.RAM_END(16'h028f)) dut (.clk, .resetn, .acc_valid, .acc_mode, .acc_addr,
    .acc_write, .acc_wdata, .gpr_index, .vec_fetch, .vec_index, .mem_rdata, .out_valid,
    .out_addr, .out_write, .out_wdata, .out_region, .out_prohibited, .mirror_hit,
    .mirror_rdata, .direct_bank_select, .register_bank_select, .vec_fetch_pending,
    .vec_target, .vec_target_valid);
  dbam_flash u_mem (.clk, .out_addr, .vec_fetch_pending, .mem_rdata);
  // region and address mean nothing on a refused access
  wire logic [20:0] seen = {out_valid, out_prohibited, out_prohibited ? 19'h0 : {out_region, out_addr}};
  // =====================================================
  // tasks
  task automatic test_done;
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [20:0] s, input logic [20:0] e);
    compares++;
    if (s !== e) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  function automatic logic [20:0] res(input logic [15:0] a, input logic [2:0] r);
    return (r == 3'h0) ? {2'b01, 19'h0} : {2'b10, r, a};
  endfunction
  task automatic acc(input logic [1:0] m, input logic [15:0] a, input logic w,
    input logic [7:0] d, input logic [2:0] g);
    @(posedge clk);
    acc_valid <= 1'b1;
    acc_mode <= m;
    acc_addr <= a;
    acc_write <= w;
    acc_wdata <= d;
    gpr_index <= g;
    @(posedge clk);
    acc_valid <= 1'b0;
    #1;
  endtask
  task automatic setb(input logic [7:0] d);
    acc(2'h0, 16'h0078, 1'b1, d, 3'h0);
    chk({register_bank_select, direct_bank_select}, d);
  endtask
  task automatic t_direct;
    for (int n = 0; n < 8; n++) begin
      setb({5'h00, n[2:0]});
      acc(2'h1, 16'h0005, 1'b0, 8'h00, 3'h0);
      chk(seen, res(16'h0005, 3'h1));
      acc(2'h1, 16'h008f, 1'b0, 8'h00, 3'h0);
      chk(seen, res(16'h008f + 16'h0080 * n[15:0], (n == 0 || n > 4) ? 3'h0 : 3'h2));
    end
  endtask
  task automatic t_map;
    setb(8'h18);
    acc(2'h2, 16'h0000, 1'b0, 8'h00, 3'h6);
    chk(seen, res(16'h011e, 3'h2));
    acc(2'h0, 16'h01ff, 1'b1, 8'h3c, 3'h0);
    chk(seen, res(16'h01ff, 3'h2));
    chk({out_write, out_wdata}, 9'h13c);
    acc(2'h1, 16'h0090, 1'b0, 8'h00, 3'h0);
    chk(seen, res(16'h0090, 3'h2));
    acc(2'h0, 16'h0f80, 1'b0, 8'h00, 3'h0);
    chk(seen, res(16'h0f80, 3'h3));
    acc(2'h1, 16'h0f80, 1'b0, 8'h00, 3'h0);
    chk(seen, res(16'h0000, 3'h0));
    acc(2'h0, 16'h0078, 1'b0, 8'h00, 3'h0);
    chk({out_valid, mirror_hit, mirror_rdata}, 10'h118);
    acc(2'h0, 16'hffbb, 1'b1, 8'h55, 3'h0);
    chk({out_write, out_region}, 4'h5);
    acc(2'h0, 16'hffba, 1'b1, 8'h55, 3'h0);
    chk({out_write, out_region}, 4'hc);
    acc(2'h0, 16'hffbf, 1'b1, 8'h55, 3'h0);
    chk({out_write, out_region}, 4'h5);
    acc(2'h0, 16'hffff, 1'b1, 8'h55, 3'h0);
    chk({out_write, out_region}, 4'h6);
  endtask
  task automatic t_vec(input logic [4:0] i);
    int k;
    @(posedge clk);
    vec_fetch <= 1'b1;
    vec_index <= i;
    @(posedge clk);
    vec_fetch <= 1'b0;
    #1;
    chk(out_addr, 16'hffc0 + {i, 1'b0});
    chk({vec_fetch_pending, out_valid, out_region}, 5'h1e);
    for (k = 1; k < 9 && vec_target_valid !== 1'b1; k++) begin
      @(posedge clk);
      #1;
    end
    if (k == 9) begin
      n_mismatch++;
      test_done;
    end
    chk(k[20:0], 21'h3);
    chk(vec_target, {8'h21, 8'hc0 + {2'b00, i, 1'b0}});
    chk({vec_fetch_pending, vec_target_valid}, 2'h1);
  endtask
  task automatic t_reset;
    setb(8'hff);
    @(posedge clk);
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    #1;
    chk({register_bank_select, direct_bank_select}, 8'h00);
    acc(2'h1, 16'h008f, 1'b0, 8'h00, 3'h0);
    chk(seen, res(16'h0000, 3'h0));
  endtask
  initial begin
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    #1;
    chk({out_valid, vec_target_valid, register_bank_select, direct_bank_select}, 21'h0);
    t_direct;
    t_map;
    t_vec(5'h00);
    t_vec(5'h1f);
    t_reset;
    test_done;
  end
endmodule
